// ==== logic/adc_pkg.sv ====
package adc_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_HALF = 5'h08;
  localparam logic [CNT_W-1:0] FRAME_FULL = 5'h10;
  localparam logic [CNT_W-1:0] MSB_CNT = 5'h02;
  localparam logic [CNT_W-1:0] LAST_CNT = 5'h11;
  localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS = 280;
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CONV_CNT_W = 4;

  typedef enum logic [2:0] {
    wait_st, sample_st, convert_st, nap_st, down_st
  } conv_state_e;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic half_word;
    logic cascade;
  } read_job_s;
endpackage

// ==== logic/bit_sync.sv ====
`timescale 1ns/1ns
module bit_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic hold_ff;

  // first stage is read by the second stage only
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= RESET_VALUE;
      hold_ff <= RESET_VALUE;
    end else begin
      meta_ff <= d;
      hold_ff <= meta_ff;
    end
  end

  assign q = hold_ff;
endmodule

// ==== logic/conv_sequencer.sv ====
`timescale 1ns/1ns
module conv_sequencer import adc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // synchronised control levels
  input wire logic start_level,
  input wire logic power_up,
  input wire logic nap_select,
  // converter core
  input wire logic [WORD_W-1:0] result_in,
  // status
  output logic busy,
  output logic read_ready,
  output logic napping,
  output logic powered_down,
  output logic result_valid,
  output logic [WORD_W-1:0] cur_result,
  output logic [WORD_W-1:0] last_result
);
  conv_state_e state_ff;
  logic level_prev_ff;
  logic pend_ff;
  logic valid_ff;
  logic [CONV_CNT_W-1:0] cnt_ff;
  logic [WORD_W-1:0] result_ff;
  logic [WORD_W-1:0] prev_result_ff;
  logic rise;
  logic fall;
  logic conv_done;

  assign rise = start_level & ~level_prev_ff;
  assign fall = ~start_level & level_prev_ff;
  assign conv_done = (state_ff == convert_st) && (cnt_ff == '0) && !fall;

  always_ff @(posedge clock) begin
    if (rst) begin
      level_prev_ff <= 1'b0;
    end else begin
      level_prev_ff <= start_level;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= wait_st;
    end else if (!power_up) begin
      state_ff <= down_st;
    end else begin
      case (state_ff)
        down_st: state_ff <= wait_st;
        wait_st, nap_st: begin
          if (rise) begin
            state_ff <= sample_st;
          end
        end
        sample_st: begin
          if (fall) begin
            state_ff <= convert_st;
          end
        end
        convert_st: begin
          if (fall) begin
            state_ff <= wait_st;
          end else if (conv_done) begin
            if (pend_ff) begin
              state_ff <= sample_st;
            end else if (nap_select) begin
              state_ff <= nap_st;
            end else begin
              state_ff <= wait_st;
            end
          end
        end
        default: state_ff <= wait_st;
      endcase
    end
  end

  // rise during conversion, except in its last cycle: sampling follows the conversion with no wait
  always_ff @(posedge clock) begin
    if (rst || state_ff != convert_st) begin
      pend_ff <= 1'b0;
    end else if (rise) begin
      pend_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (state_ff == sample_st && fall) begin
      cnt_ff <= CONV_CNT_W'(CONV_CYCLES - 1);
    end else if (state_ff == convert_st && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      valid_ff <= 1'b0;
      result_ff <= RESULT_RESET;
      prev_result_ff <= RESULT_RESET;
    end else if (state_ff == convert_st && fall) begin
      valid_ff <= 1'b0;
    end else if (conv_done) begin
      valid_ff <= 1'b1;
      result_ff <= result_in;
      prev_result_ff <= result_ff;
    end
  end

  assign busy = (state_ff == convert_st);
  assign read_ready = (state_ff == wait_st) || (state_ff == sample_st) ||
                      (state_ff == nap_st);
  assign napping = (state_ff == nap_st);
  assign powered_down = (state_ff == down_st);
  assign result_valid = valid_ff;
  assign cur_result = result_ff;
  assign last_result = prev_result_ff;

  property p_conv_end;
    @(posedge clock) disable iff (rst)
    conv_done && power_up |=> !busy && result_valid;
  endproperty
  a_conv_end: assert property (p_conv_end)
    else $error("busy did not fall with a valid result at conversion end");

  property p_abort;
    @(posedge clock) disable iff (rst)
    busy && fall && power_up |=> !busy && !result_valid;
  endproperty
  a_abort: assert property (p_abort)
    else $error("conversion abort did not invalidate data");

  property p_power_down;
    @(posedge clock) disable iff (rst)
    !power_up |=> powered_down && !busy;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power down not entered");

  property p_nap;
    @(posedge clock) disable iff (rst)
    conv_done && power_up && nap_select && !pend_ff |=> napping;
  endproperty
  a_nap: assert property (p_nap)
    else $error("nap not entered at conversion end");

  property p_sample_start;
    @(posedge clock) disable iff (rst)
    (state_ff == wait_st) && rise && power_up |=> state_ff == sample_st;
  endproperty
  a_sample_start: assert property (p_sample_start)
    else $error("rising convert start did not begin sampling");

  c_abort: cover property (@(posedge clock) disable iff (rst)
    busy && fall);
endmodule

// ==== logic/adc_serial_readout_control.sv ====
`timescale 1ns/1ns
module adc_serial_readout_control import adc_pkg::*; (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial i/o clock sources
  input wire logic osc_clock,
  input wire logic ext_io_clock,
  // configuration pins
  input wire logic clock_source_select,
  input wire logic chain_topology_select,
  input wire logic read_latency_select,
  input wire logic half_word_select,
  input wire logic clock_out_gate_select,
  input wire logic nap_select,
  input wire logic power_down_n,
  // control pins
  input wire logic chip_select_n,
  input wire logic convert_start_single_ended_n,
  input wire logic convert_start_differential_n,
  input wire logic read_request_n,
  // chain inputs
  input wire logic chain_serial_in,
  input wire logic chain_frame_sync_in,
  // converter core
  input wire logic [WORD_W-1:0] conversion_result,
  // status
  output logic busy,
  output logic bus_in_use,
  output logic nap_state,
  output logic power_down_state,
  // serial outputs
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic frame_sync_out,
  output logic frame_sync_oe
);
  logic io_clock;
  logic conv_se_s;
  logic conv_diff_s;
  logic pwr_n_s;
  logic nap_s;
  logic cs_n_s;
  logic rd_n_s;
  logic half_s;
  logic cascade_s;
  logic latency_s;
  logic done_s;
  logic seq_ready;
  logic seq_valid;
  logic [WORD_W-1:0] cur_word;
  logic [WORD_W-1:0] last_word;
  logic rd_prev_ff;
  logic rd_fall;
  logic start_read;
  logic start_tgl_ff;
  logic done_seen_ff;
  logic bus_in_use_ff;
  read_job_s job_ff;

  // strap-style select: only change it under reset, the clock mux is not glitch free
  assign io_clock = clock_source_select ? osc_clock : ext_io_clock;

  bit_sync #(.RESET_VALUE(1'b0)) u_sync_cse (.clock(clock), .rst(rst),
    .d(convert_start_single_ended_n), .q(conv_se_s));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_csd (.clock(clock), .rst(rst),
    .d(convert_start_differential_n), .q(conv_diff_s));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_pwr (.clock(clock), .rst(rst),
    .d(power_down_n), .q(pwr_n_s));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_nap (.clock(clock), .rst(rst),
    .d(nap_select), .q(nap_s));
  bit_sync #(.RESET_VALUE(1'b1)) u_sync_cs (.clock(clock), .rst(rst),
    .d(chip_select_n), .q(cs_n_s));
  bit_sync #(.RESET_VALUE(1'b1)) u_sync_rd (.clock(clock), .rst(rst),
    .d(read_request_n), .q(rd_n_s));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_half (.clock(clock), .rst(rst),
    .d(half_word_select), .q(half_s));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_casc (.clock(clock), .rst(rst),
    .d(chain_topology_select), .q(cascade_s));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_lat (.clock(clock), .rst(rst),
    .d(read_latency_select), .q(latency_s));

  conv_sequencer u_seq (
    .clock(clock),
    .rst(rst),
    .start_level(conv_se_s | conv_diff_s),
    .power_up(pwr_n_s),
    .nap_select(nap_s),
    .result_in(conversion_result),
    .busy(busy),
    .read_ready(seq_ready),
    .napping(nap_state),
    .powered_down(power_down_state),
    .result_valid(seq_valid),
    .cur_result(cur_word),
    .last_result(last_word)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_prev_ff <= 1'b1;
    end else begin
      rd_prev_ff <= rd_n_s;
    end
  end

  assign rd_fall = rd_prev_ff & ~rd_n_s;
  // a read request is ignored until the previous one has drained the link
  assign start_read = rd_fall && !cs_n_s && seq_ready && pwr_n_s &&
                      !bus_in_use_ff;

  // job stays stable while the link domain reads it
  always_ff @(posedge clock) begin
    if (rst) begin
      job_ff <= '0;
    end else if (start_read) begin
      job_ff.word <= latency_s ? last_word : cur_word;
      job_ff.half_word <= half_s;
      job_ff.cascade <= cascade_s;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      start_tgl_ff <= 1'b0;
    end else if (start_read) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done_seen_ff <= 1'b0;
    end else begin
      done_seen_ff <= done_s;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_in_use_ff <= 1'b0;
    end else if (start_read) begin
      bus_in_use_ff <= 1'b1;
    end else if (done_s != done_seen_ff) begin
      bus_in_use_ff <= 1'b0;
    end
  end

  assign bus_in_use = bus_in_use_ff;

  // link side, on the selected i/o clock
  logic lrst;
  logic start_l;
  logic cs_n_l;
  logic pwr_n_l;
  logic gate_l;
  logic cascade_l;
  logic chain_in_l;
  logic chain_sync_l;
  logic start_seen_ff;
  logic go;
  logic active_ff;
  logic pass_ff;
  logic oe_ff;
  logic dout_ff;
  logic sync_ff;
  logic done_tgl_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic stop_l;

  bit_sync #(.RESET_VALUE(1'b1)) u_lsync_rst (.clock(io_clock),
    .rst(1'b0), .d(rst), .q(lrst));
  bit_sync #(.RESET_VALUE(1'b0)) u_lsync_go (.clock(io_clock),
    .rst(lrst), .d(start_tgl_ff), .q(start_l));
  bit_sync #(.RESET_VALUE(1'b1)) u_lsync_cs (.clock(io_clock),
    .rst(lrst), .d(chip_select_n), .q(cs_n_l));
  bit_sync #(.RESET_VALUE(1'b0)) u_lsync_pwr (.clock(io_clock),
    .rst(lrst), .d(power_down_n), .q(pwr_n_l));
  bit_sync #(.RESET_VALUE(1'b0)) u_lsync_gate (.clock(io_clock),
    .rst(lrst), .d(clock_out_gate_select), .q(gate_l));
  bit_sync #(.RESET_VALUE(1'b0)) u_lsync_casc (.clock(io_clock),
    .rst(lrst), .d(chain_topology_select), .q(cascade_l));
  bit_sync #(.RESET_VALUE(1'b0)) u_lsync_chain (.clock(io_clock),
    .rst(lrst), .d(chain_serial_in), .q(chain_in_l));
  bit_sync #(.RESET_VALUE(1'b0)) u_lsync_syi (.clock(io_clock),
    .rst(lrst), .d(chain_frame_sync_in), .q(chain_sync_l));
  bit_sync #(.RESET_VALUE(1'b0)) u_sync_done (.clock(clock), .rst(rst),
    .d(done_tgl_ff), .q(done_s));

  assign go = (start_l != start_seen_ff);
  assign stop_l = cs_n_l || !pwr_n_l;
  assign nxt_cnt = cnt_ff + 5'h01;

  always_ff @(posedge io_clock) begin
    if (lrst) begin
      start_seen_ff <= 1'b0;
    end else begin
      start_seen_ff <= start_l;
    end
  end

  // a deselect mid-frame still hands the bus back to the system side
  always_ff @(posedge io_clock) begin
    if (lrst) begin
      active_ff <= 1'b0;
      cnt_ff <= '0;
      done_tgl_ff <= 1'b0;
    end else if (stop_l) begin
      active_ff <= 1'b0;
      if (active_ff) begin
        done_tgl_ff <= ~done_tgl_ff;
      end
    end else if (go) begin
      active_ff <= 1'b1;
      cnt_ff <= '0;
    end else if (active_ff) begin
      cnt_ff <= nxt_cnt;
      if (nxt_cnt == LAST_CNT) begin
        active_ff <= 1'b0;
        done_tgl_ff <= ~done_tgl_ff;
      end
    end
  end

  // driven from read start, held high-z after reset and on deselect
  always_ff @(posedge io_clock) begin
    if (lrst) begin
      oe_ff <= 1'b0;
    end else if (stop_l) begin
      oe_ff <= 1'b0;
    end else if (go) begin
      oe_ff <= 1'b1;
    end
  end

  // daisy chain: after our own word, forward the upstream stream
  always_ff @(posedge io_clock) begin
    if (lrst || stop_l || go) begin
      pass_ff <= 1'b0;
    end else if (active_ff && nxt_cnt == LAST_CNT && !job_ff.cascade) begin
      pass_ff <= 1'b1;
    end
  end

  always_ff @(posedge io_clock) begin
    if (lrst) begin
      dout_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (go) begin
      dout_ff <= 1'b0;
      sync_ff <= 1'b1;
    end else if (active_ff) begin
      if (nxt_cnt >= MSB_CNT) begin
        dout_ff <= job_ff.word[4'(LAST_CNT - nxt_cnt)];
      end else begin
        dout_ff <= 1'b0;
      end
      sync_ff <= (nxt_cnt == FRAME_FULL) ||
                 (job_ff.half_word && nxt_cnt == FRAME_HALF);
    end else if (pass_ff) begin
      dout_ff <= chain_in_l;
      sync_ff <= chain_sync_l;
    end else begin
      dout_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
  end

  assign serial_data_out = dout_ff;
  assign frame_sync_out = sync_ff;
  assign serial_data_oe = oe_ff;
  assign frame_sync_oe = oe_ff;
  assign serial_clock_out = io_clock;
  assign serial_clock_oe = cascade_l ? gate_l : 1'b1;

  property p_start_bus;
    @(posedge clock) disable iff (rst)
    start_read |=> bus_in_use &&
      job_ff.word == $past(latency_s ? last_word : cur_word);
  endproperty
  a_start_bus: assert property (p_start_bus)
    else $error("bus in use not raised at read start");

  property p_no_start_deselected;
    @(posedge clock) disable iff (rst)
    !bus_in_use && cs_n_s |=> !bus_in_use;
  endproperty
  a_no_start_deselected: assert property (p_no_start_deselected)
    else $error("read started while deselected");

  property p_msb;
    @(posedge io_clock) disable iff (lrst)
    go && !stop_l ##1 !stop_l[*2] |=> serial_data_out == job_ff.word[15];
  endproperty
  a_msb: assert property (p_msb)
    else $error("msb not on second rising edge of frame");

  property p_frame_full;
    @(posedge io_clock) disable iff (lrst)
    go && !stop_l && !job_ff.half_word |-> ##1 frame_sync_out
      ##16 (frame_sync_out || stop_l);
  endproperty
  a_frame_full: assert property (p_frame_full)
    else $error("full frame not 16 clocks");

  property p_frame_half;
    @(posedge io_clock) disable iff (lrst)
    go && !stop_l && job_ff.half_word |-> ##1 frame_sync_out
      ##1 !frame_sync_out ##7 (frame_sync_out || stop_l);
  endproperty
  a_frame_half: assert property (p_frame_half)
    else $error("half frame not 8 clocks");

  property p_hiz;
    @(posedge io_clock) disable iff (lrst)
    stop_l |=> !serial_data_oe && !frame_sync_oe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("outputs driven while deselected");

  property p_clock_gate;
    @(posedge io_clock) disable iff (lrst)
    cascade_l && !gate_l |-> !serial_clock_oe;
  endproperty
  a_clock_gate: assert property (p_clock_gate)
    else $error("serial clock driven with gate select low");

  c_read: cover property (@(posedge clock) disable iff (rst)
    start_read && seq_valid);
  c_half: cover property (@(posedge io_clock) disable iff (lrst)
    go && job_ff.half_word);
  c_pass: cover property (@(posedge io_clock) disable iff (lrst) pass_ff);
  c_lat: cover property (@(posedge clock) disable iff (rst)
    start_read && latency_s);
endmodule

// ==== tb/host_rx_model.sv ====
`timescale 1ns/1ns
module host_rx_model import adc_pkg::*; (
  // serial link from the converter
  input wire logic serial_clock_out,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe,
  // upstream chain inputs of the converter
  output logic chain_serial_in,
  output logic chain_frame_sync_in,
  // what the receiver recovered
  output logic [WORD_W-1:0] word,
  output int gap,
  output int frames
);
  logic [WORD_W-1:0] sr = '0;
  logic prev_sync = 1'b0;
  int cnt = 0;
  wire sync_w = frame_sync_oe & frame_sync_out;

  // single or first device: nothing upstream, chain inputs held low
  assign chain_serial_in = 1'b0;
  assign chain_frame_sync_in = 1'b0;

  initial begin
    word = '0;
    gap = 0;
    frames = 0;
  end

  // bits launched on rising edges are taken on the falling edge
  always @(negedge serial_clock_out) begin
    if (serial_data_oe === 1'b1) begin
      sr <= {sr[WORD_W-2:0], serial_data_out};
      // word complete one clock after a frame start
      if (prev_sync)
        word <= {sr[WORD_W-2:0], serial_data_out};
      if (sync_w && !prev_sync) begin
        gap <= cnt;
        cnt <= 1;
        frames <= frames + 1;
      end else
        cnt <= cnt + 1;
      prev_sync <= sync_w;
    end else
      prev_sync <= 1'b0;
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top import adc_pkg::*;;
  logic clock = 0, rst = 1, osc_clock = 0, ext_io_clock = 0;
  logic clock_source_select = 1, chain_topology_select = 0;
  logic read_latency_select = 0, half_word_select = 0;
  logic clock_out_gate_select = 0, nap_select = 0, power_down_n = 1;
  logic chip_select_n = 0, read_request_n = 1;
  logic convert_start_single_ended_n = 0, convert_start_differential_n = 0;
  logic chain_serial_in, chain_frame_sync_in;
  logic [WORD_W-1:0] conversion_result = '0, word;
  logic busy, bus_in_use, nap_state, power_down_state;
  logic serial_clock_out, serial_clock_oe, serial_data_out;
  logic serial_data_oe, frame_sync_out, frame_sync_oe;
  int gap, frames, failures = 0, n_tests = 0;

  initial forever #20 clock = ~clock;
  initial begin
    #7;
    forever #16 ext_io_clock = ~ext_io_clock;
  end
  // 5 ns oscillator stand-in; 1 ns grid forces an uneven duty
  initial forever begin
    #3 osc_clock = 1;
    #2 osc_clock = 0;
  end

  adc_serial_readout_control dut (.clock, .rst, .osc_clock, .ext_io_clock,
    .clock_source_select, .chain_topology_select, .read_latency_select,
    .half_word_select, .clock_out_gate_select, .nap_select, .power_down_n,
    .chip_select_n, .convert_start_single_ended_n,
    .convert_start_differential_n, .read_request_n, .chain_serial_in,
    .chain_frame_sync_in, .conversion_result, .busy, .bus_in_use, .nap_state,
    .power_down_state, .serial_clock_out, .serial_clock_oe, .serial_data_out,
    .serial_data_oe, .frame_sync_out, .frame_sync_oe);

  host_rx_model partner (.serial_clock_out, .serial_data_out, .serial_data_oe,
    .frame_sync_out, .frame_sync_oe, .chain_serial_in, .chain_frame_sync_in,
    .word, .gap, .frames);

  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // source may only change under reset: the clock mux is not glitch free
  task automatic t_clk_src;
    time t0;
    for (int s = 1; s >= 0; s--) begin
      rst = 1;
      clock_source_select = s[0];
      cyc(6);
      rst = 0;
      cyc(4);
      @(posedge serial_clock_out);
      t0 = $time;
      @(posedge serial_clock_out);
      chk($time - t0 == (s ? 5 : 32), "io clock period");
      chk(serial_data_oe === 1'b0, "data enabled before read");
      chk(frame_sync_oe === 1'b0, "sync enabled before read");
      cyc(1);
    end
    $display("test clock source done");
  endtask

  // unused start input stays low; k returns busy length in clocks
  task automatic conv(input logic dif, input logic [15:0] r, output int k);
    conversion_result = r;
    if (dif)
      convert_start_differential_n = 1;
    else
      convert_start_single_ended_n = 1;
    cyc(4);
    convert_start_differential_n = 0;
    convert_start_single_ended_n = 0;
    k = 0;
    while (busy !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    chk(busy === 1'b1, "busy not raised");
    k = 0;
    while (busy === 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic rd(input logic half, lat, input logic [15:0] exp);
    int k, f0;
    half_word_select = half;
    read_latency_select = lat;
    f0 = frames;
    read_request_n = 0;
    k = 0;
    while (bus_in_use !== 1'b1 && k < 8) begin
      cyc(1);
      k++;
    end
    chk(bus_in_use === 1'b1, "bus in use not raised");
    read_request_n = 1;
    while (bus_in_use === 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    cyc(2);
    chk(serial_data_oe === 1'b1, "data not enabled");
    chk(word === exp, "received word");
    chk(gap == (half ? 8 : 16), "frame length");
    chk(frames - f0 == (half ? 3 : 2), "frame count");
    chip_select_n = 1;
    cyc(4);
    chk(serial_data_oe === 1'b0, "data not released");
    chk(frame_sync_oe === 1'b0, "sync not released");
    chk(serial_clock_oe === 1'b1, "clock released");
    chip_select_n = 0;
    cyc(4);
  endtask

  task automatic t_convert;
    int k;
    for (int d = 0; d < 2; d++) begin
      conv(d[0], 16'h1234, k);
      chk(k == CONV_CYCLES, "conversion length");
    end
    $display("test convert done");
  endtask

  task automatic t_reads;
    int k;
    conv(0, 16'ha5c3, k);
    rd(0, 0, 16'ha5c3);
    rd(1, 0, 16'ha5c3);
    conv(1, 16'h3c5a, k);
    rd(0, 1, 16'ha5c3);
    read_latency_select = 0;
    $display("test reads done");
  endtask

  task automatic t_abort;
    int k;
    conv(0, 16'h0f0f, k);
    convert_start_single_ended_n = 1;
    cyc(4);
    convert_start_single_ended_n = 0;
    k = 0;
    while (busy !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    convert_start_single_ended_n = 1;
    cyc(1);
    convert_start_single_ended_n = 0;
    k = 0;
    while (busy === 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    chk(k > 0 && k < CONV_CYCLES - 1, "abort length");
    $display("test abort done");
  endtask

  task automatic t_cascade;
    chain_topology_select = 1;
    cyc(4);
    chk(serial_clock_oe === 1'b0, "gated clock driven");
    clock_out_gate_select = 1;
    cyc(4);
    chk(serial_clock_oe === 1'b1, "clock not driven");
    chain_topology_select = 0;
    clock_out_gate_select = 0;
    cyc(4);
    chk(serial_clock_oe === 1'b1, "daisy clock gated");
    $display("test cascade done");
  endtask

  task automatic t_power;
    int k;
    power_down_n = 0;
    cyc(4);
    chk(power_down_state === 1'b1, "not powered down");
    convert_start_single_ended_n = 1;
    cyc(4);
    convert_start_single_ended_n = 0;
    k = 0;
    repeat (14) begin
      cyc(1);
      if (busy !== 1'b0)
        k++;
    end
    chk(k == 0, "converted in power down");
    power_down_n = 1;
    cyc(4);
    chk(power_down_state === 1'b0, "still powered down");
    chk(serial_data_oe === 1'b0, "data enabled after wake");
    conv(0, 16'h7ffe, k);
    rd(0, 0, 16'h7ffe);
    $display("test power down done");
  endtask

  task automatic t_nap;
    int k;
    nap_select = 1;
    conv(0, 16'h8001, k);
    cyc(2);
    chk(nap_state === 1'b1, "no nap after conversion");
    rd(0, 0, 16'h8001);
    convert_start_single_ended_n = 1;
    cyc(4);
    chk(nap_state === 1'b0, "nap kept while sampling");
    nap_select = 0;
    convert_start_single_ended_n = 0;
    cyc(14);
    $display("test nap done");
  endtask

  initial begin
    t_clk_src();
    t_convert();
    t_reads();
    t_abort();
    t_cascade();
    t_power();
    t_nap();
    test_done();
  end

  // whole sequence needs about 350 clocks
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule
